// >>> design/bic_pkg.sv
// constants, operation codes and field widths shared by the branch and inc/dec executor.
// assumes one clock domain and no software-visible registers.
// Operation
// [RULE1] branch always jumps, two cycles, flags kept
// [RULE2] branch literal loads program counter bits ten..zero
// [RULE3] counter bits twelve, eleven from latch bits four, three
// [RULE4] decrement, update zero flag, destination bit steers
// [RULE5] increment, update zero flag, destination bit steers
// [RULE6] decrement-skip steers result, flags untouched
// [RULE7] decrement-skip zero result replaces next with idle
// [RULE8] increment-skip steers result, flags untouched
// [RULE9] increment-skip zero result replaces next with idle
// [RULE10] register address seven bits, destination one bit
// [RULE11] zero flag set when wrapped result equals zero
package bic_pkg;
  // field widths
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int FADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int LATCH_W = 8;
  // field positions of the latch bits that extend the branch target
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  // reset values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;
  localparam logic [LIT_W-1:0] LIT_RESET = 11'h000;
  // arithmetic constants
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ALL = 8'hFF;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // destination selector values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  // operations the executor accepts
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_JUMP,
    OP_DEC,
    OP_INC,
    OP_DEC_SKIP,
    OP_INC_SKIP
  } bic_op_e;
endpackage

// >>> design/bic_alu_if.sv
// interface between the executor core and its increment/decrement unit.
// assumes both ends share one clock; the path is purely combinational.
`timescale 1ns/1ns
`default_nettype none
interface bic_alu_if;
  import bic_pkg::*;
  logic [DATA_W-1:0] operand; // value read from the register file
  logic is_dec; // high selects subtract one
  logic [DATA_W-1:0] result; // wrapped eight-bit result
  logic zero; // result equals zero
  // arithmetic unit end
  modport alu (input operand, input is_dec, output result, output zero);
  // core end
  modport core (output operand, output is_dec, input result, input zero);
endinterface
`default_nettype wire

// >>> design/bic_incdec.sv
// increment/decrement unit with wrap-around and zero detect.
// assumes operand is stable for the cycle in which the core samples result.
`timescale 1ns/1ns
`default_nettype none
module bic_incdec (
  // arithmetic link to the core
  bic_alu_if.alu alu
);
  import bic_pkg::*;
  // eight-bit target makes the sum wrap modulo 256
  assign alu.result = alu.is_dec ? alu.operand - DATA_ONE : alu.operand + DATA_ONE; // [RULE11]
  // zero detect feeds the flag and the skip decision
  assign alu.zero = (alu.result == DATA_RESET); // [RULE11]
endmodule
`default_nettype wire

// >>> design/bic_exec.sv
// branch and increment/decrement executor: each instruction cycle is two ref_clk cycles,
// an accept cycle and an execute cycle.
// assumes the register file answers freg_rdata combinationally from freg_addr, on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module bic_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // instruction issue
  input wire logic instr_valid,
  output logic instr_ready,
  input wire bic_pkg::bic_op_e instr_op,
  input wire logic [bic_pkg::LIT_W-1:0] instr_lit,
  input wire logic [bic_pkg::FADDR_W-1:0] instr_faddr,
  input wire logic instr_dest,
  // program counter high latch
  input wire logic [bic_pkg::LATCH_W-1:0] pc_high_latch,
  // register file port
  output logic [bic_pkg::FADDR_W-1:0] freg_addr,
  input wire logic [bic_pkg::DATA_W-1:0] freg_rdata,
  output logic freg_we,
  output logic [bic_pkg::DATA_W-1:0] freg_wdata,
  // core state
  output logic [bic_pkg::PC_W-1:0] pc,
  output logic [bic_pkg::DATA_W-1:0] acc,
  output logic zero_flag,
  output logic idle_slot
);
  import bic_pkg::*;

  typedef enum logic {ST_ACCEPT, ST_EXEC} bic_state_e;

  bic_state_e state_reg, state_next; // two-phase instruction cycle
  bic_op_e op_reg, op_next; // latched operation
  logic [LIT_W-1:0] lit_reg, lit_next; // latched branch literal
  logic [1:0] hi_reg, hi_next; // latched upper target bits
  logic [FADDR_W-1:0] faddr_reg, faddr_next; // latched register address
  logic dest_reg, dest_next; // latched destination selector
  logic discard_reg, discard_next; // next issued instruction becomes idle
  logic [PC_W-1:0] pc_reg, pc_next; // program counter
  logic [DATA_W-1:0] acc_reg, acc_next; // accumulator
  logic z_reg, z_next; // zero flag
  logic we_reg, we_next; // register file write strobe
  logic [DATA_W-1:0] wdata_reg, wdata_next; // register file write data
  logic idle_reg, idle_next; // idle slot pulse

  bic_alu_if alu_link ();

  // increment/decrement unit
  bic_incdec u_incdec (
    .alu(alu_link.alu)
  );

  // decode of the latched operation
  wire logic take = (state_reg == ST_ACCEPT) && instr_valid;
  wire logic in_exec = (state_reg == ST_EXEC);
  wire logic op_is_jump = (op_reg == OP_JUMP);
  wire logic op_is_plain = (op_reg == OP_DEC) || (op_reg == OP_INC);
  wire logic op_is_skip = (op_reg == OP_DEC_SKIP) || (op_reg == OP_INC_SKIP);
  wire logic op_is_dec = (op_reg == OP_DEC) || (op_reg == OP_DEC_SKIP);
  wire logic op_arith = op_is_plain || op_is_skip;
  wire logic to_acc = op_arith && (dest_reg == DEST_ACC); // [RULE4] [RULE5] [RULE6] [RULE8]
  wire logic to_reg = op_arith && (dest_reg == DEST_REG); // [RULE4] [RULE5] [RULE6] [RULE8]
  wire logic [PC_W-1:0] jump_target = {hi_reg, lit_reg}; // [RULE2] [RULE3]

  assign alu_link.operand = freg_rdata;
  assign alu_link.is_dec = op_is_dec;

  // next-state and datapath decisions
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    lit_next = lit_reg;
    hi_next = hi_reg;
    faddr_next = faddr_reg;
    dest_next = dest_reg;
    discard_next = discard_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    z_next = z_reg;
    we_next = 1'b0;
    wdata_next = wdata_reg;
    idle_next = 1'b0;
    case (state_reg)
      ST_ACCEPT: begin
        if (take) begin
          state_next = ST_EXEC;
          pc_next = pc_reg + PC_STEP;
          if (discard_reg) begin
            // discarded instruction runs as an idle slot
            op_next = OP_IDLE; // [RULE7] [RULE9]
            discard_next = 1'b0;
            idle_next = 1'b1;
          end else begin
            op_next = instr_op;
            lit_next = instr_lit;
            hi_next = pc_high_latch[LATCH_HI:LATCH_LO]; // [RULE3]
            faddr_next = instr_faddr; // [RULE10]
            dest_next = instr_dest; // [RULE10]
          end
        end
      end
      ST_EXEC: begin
        state_next = ST_ACCEPT;
        if (op_is_jump) begin
          // branch always taken; its second cycle is the idle slot that follows
          pc_next = jump_target; // [RULE1] [RULE2] [RULE3]
          discard_next = 1'b1; // [RULE1]
        end
        if (to_acc) begin
          acc_next = alu_link.result; // [RULE4] [RULE5] [RULE6] [RULE8]
        end
        if (to_reg) begin
          we_next = 1'b1; // [RULE4] [RULE5] [RULE6] [RULE8]
          wdata_next = alu_link.result;
        end
        if (op_is_plain) begin
          z_next = alu_link.zero; // [RULE4] [RULE5] [RULE11]
        end
        if (op_is_skip) begin
          discard_next = alu_link.zero; // [RULE7] [RULE9]
        end
      end
      default: begin
        state_next = ST_ACCEPT;
      end
    endcase
  end

  // control state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_ACCEPT;
      op_reg <= OP_IDLE;
      discard_reg <= 1'b0;
      pc_reg <= PC_RESET;
      idle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      discard_reg <= discard_next;
      pc_reg <= pc_next;
      idle_reg <= idle_next;
    end
  end

  // latched operands
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lit_reg <= LIT_RESET;
      hi_reg <= PC_RESET[PC_W-1:LIT_W];
      faddr_reg <= FADDR_RESET;
      dest_reg <= DEST_ACC;
    end else begin
      lit_reg <= lit_next;
      hi_reg <= hi_next;
      faddr_reg <= faddr_next;
      dest_reg <= dest_next;
    end
  end

  // architectural data state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc_reg <= DATA_RESET;
      z_reg <= 1'b0;
      we_reg <= 1'b0;
      wdata_reg <= DATA_RESET;
    end else begin
      acc_reg <= acc_next;
      z_reg <= z_next;
      we_reg <= we_next;
      wdata_reg <= wdata_next;
    end
  end

  // outputs
  assign instr_ready = (state_reg == ST_ACCEPT);
  assign freg_addr = faddr_reg;
  assign freg_we = we_reg;
  assign freg_wdata = wdata_reg;
  assign pc = pc_reg;
  assign acc = acc_reg;
  assign zero_flag = z_reg;
  assign idle_slot = idle_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_jump_target;
    in_exec && op_is_jump |=> pc_reg == {$past(hi_reg), $past(lit_reg)};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("branch target wrong"); // [RULE2] [RULE3]

  property p_jump_flags;
    in_exec && op_is_jump |=> $stable(z_reg) && discard_reg;
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("branch changed flag or no idle slot"); // [RULE1]

  property p_jump_slot;
    in_exec && op_is_jump ##1 take |=> op_reg == OP_IDLE && idle_reg ##1 pc_reg == $past(pc_reg, 2) + PC_STEP;
  endproperty
  a_jump_slot: assert property (p_jump_slot) else $error("branch second cycle not idle"); // [RULE1]

  property p_dec_zero;
    in_exec && op_reg == OP_DEC |=> z_reg == ($past(freg_rdata) == DATA_ONE);
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("decrement zero flag wrong"); // [RULE4] [RULE11]

  property p_inc_zero;
    in_exec && op_reg == OP_INC |=> z_reg == ($past(freg_rdata) == DATA_ALL);
  endproperty
  a_inc_zero: assert property (p_inc_zero) else $error("increment zero flag wrong"); // [RULE5] [RULE11]

  property p_dec_acc;
    in_exec && op_is_dec && dest_reg == DEST_ACC |=> acc_reg == $past(freg_rdata) - DATA_ONE && !we_reg;
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to accumulator wrong"); // [RULE4] [RULE6]

  property p_inc_reg;
    in_exec && op_arith && !op_is_dec && dest_reg == DEST_REG
      |=> we_reg && wdata_reg == $past(freg_rdata) + DATA_ONE && $stable(acc_reg);
  endproperty
  a_inc_reg: assert property (p_inc_reg) else $error("increment to register wrong"); // [RULE5] [RULE8]

  property p_skip_flags;
    in_exec && op_is_skip |=> $stable(z_reg);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip op changed flag"); // [RULE6] [RULE8]

  property p_skip_decide;
    in_exec && op_is_skip |=> discard_reg == ($past(freg_rdata) == (op_reg == OP_DEC_SKIP ? DATA_ONE : DATA_ALL));
  endproperty
  a_skip_decide: assert property (p_skip_decide) else $error("skip decision wrong"); // [RULE7] [RULE9]

  property p_addr_held;
    take && !discard_reg |=> freg_addr == $past(instr_faddr) && dest_reg == $past(instr_dest);
  endproperty
  a_addr_held: assert property (p_addr_held) else $error("operand address not latched"); // [RULE10]

  c_jump: cover property (in_exec && op_is_jump ##2 idle_reg);
  c_dec_skip: cover property (in_exec && op_reg == OP_DEC_SKIP && alu_link.zero);
  c_inc_wrap: cover property (in_exec && op_reg == OP_INC_SKIP && freg_rdata == DATA_ALL);
  c_plain_reg: cover property (in_exec && op_is_plain && to_reg);
endmodule
`default_nettype wire

// >>> tb/bic_regfile_model.sv
// register file model facing the executor's register port.
// assumes the bench seeds and reads mem directly between instructions.
`timescale 1ns/1ns
`default_nettype none
module bic_regfile_model (
  // clock
  input wire logic ref_clk,
  // register file port
  input wire logic [bic_pkg::FADDR_W-1:0] freg_addr,
  output logic [bic_pkg::DATA_W-1:0] freg_rdata,
  input wire logic freg_we,
  input wire logic [bic_pkg::DATA_W-1:0] freg_wdata
);
  import bic_pkg::*;
  logic [DATA_W-1:0] mem [0:127]; // one byte per register address
  // reads follow the address at once
  assign freg_rdata = mem[freg_addr];
  // writes land on the edge that samples the strobe
  always @(posedge ref_clk) begin
    if (freg_we) begin
      mem[freg_addr] <= freg_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/branch_and_incdec_exec_tb.sv
// self-checking bench for the branch and inc/dec executor.
// assumes inputs change on the falling edge and outputs settle before it.
`timescale 1ns/1ns
`default_nettype none
module branch_and_incdec_exec_tb;
  import bic_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  bic_op_e instr_op = OP_IDLE;
  logic [LIT_W-1:0] instr_lit = LIT_RESET;
  logic [FADDR_W-1:0] instr_faddr = FADDR_RESET;
  logic instr_dest = DEST_ACC;
  logic [LATCH_W-1:0] pc_high_latch = 8'h00;
  logic instr_ready, freg_we, zero_flag, idle_slot;
  logic [FADDR_W-1:0] freg_addr;
  logic [DATA_W-1:0] freg_rdata, freg_wdata, acc;
  logic [PC_W-1:0] pc;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  // expected core state, worked out here
  logic [PC_W-1:0] exp_pc = PC_RESET;
  logic [DATA_W-1:0] exp_acc = DATA_RESET;
  logic exp_zero = 1'b0;
  logic skip_pend = 1'b0; // next taken instruction must be discarded
  always #10 ref_clk = ~ref_clk;
  bic_exec i_bic_exec (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .instr_lit(instr_lit), .instr_faddr(instr_faddr), .instr_dest(instr_dest),
    .pc_high_latch(pc_high_latch), .freg_addr(freg_addr), .freg_rdata(freg_rdata), .freg_we(freg_we),
    .freg_wdata(freg_wdata), .pc(pc), .acc(acc), .zero_flag(zero_flag), .idle_slot(idle_slot));
  bic_regfile_model i_bic_regfile_model (.ref_clk(ref_clk), .freg_addr(freg_addr), .freg_rdata(freg_rdata),
    .freg_we(freg_we), .freg_wdata(freg_wdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // issue one instruction and judge its effects
  task automatic run(input bic_op_e op, input logic [FADDR_W-1:0] f, input logic dest,
                     input logic [DATA_W-1:0] val, input logic [LIT_W-1:0] lit);
    logic [DATA_W-1:0] res;
    logic wr;
    int n;
    res = (op == OP_INC || op == OP_INC_SKIP) ? val + DATA_ONE : val - DATA_ONE;
    wr = (op != OP_JUMP) && (dest == DEST_REG);
    i_bic_regfile_model.mem[f] = val;
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    instr_valid = 1'b1;
    instr_op = op;
    instr_faddr = f;
    instr_dest = dest;
    instr_lit = lit;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    // taken one edge ago: pc has stepped, an idle pulse stands only in this cycle
    exp_pc = exp_pc + PC_STEP;
    chk(16'(pc), 16'(exp_pc));
    chk(16'(idle_slot), 16'(skip_pend));
    chk(16'(instr_ready), 16'h0);
    if (!skip_pend) begin
      chk(16'(freg_addr), 16'(f));
    end
    if (skip_pend) begin
      skip_pend = 1'b0;
      @(negedge ref_clk);
      chk(16'(acc), 16'(exp_acc));
      chk(16'(freg_we), 16'h0);
      return;
    end
    @(negedge ref_clk);
    if (op == OP_JUMP) begin
      exp_pc = {pc_high_latch[LATCH_HI:LATCH_LO], lit};
      skip_pend = 1'b1;
    end else if (dest == DEST_ACC) begin
      exp_acc = res;
    end
    if (op == OP_DEC || op == OP_INC) begin
      exp_zero = (res == 8'h00);
    end
    if ((op == OP_DEC_SKIP || op == OP_INC_SKIP) && res == 8'h00) begin
      skip_pend = 1'b1;
    end
    chk(16'(pc), 16'(exp_pc));
    chk(16'(acc), 16'(exp_acc));
    chk(16'(zero_flag), 16'(exp_zero));
    chk(16'(freg_we), 16'(wr));
    // only a register write needs one more edge; other ops let the next one follow at once
    if (wr) begin
      @(negedge ref_clk);
      chk(16'(i_bic_regfile_model.mem[f]), 16'(res));
    end
  endtask
  task automatic t_plain();
    run(OP_INC, 7'h7F, DEST_REG, 8'h7F, LIT_RESET);
    run(OP_INC, 7'h00, DEST_ACC, 8'hFF, LIT_RESET);
    run(OP_DEC, 7'h55, DEST_REG, 8'h00, LIT_RESET);
    run(OP_DEC, 7'h01, DEST_ACC, 8'h01, LIT_RESET);
    $display("test plain done");
  endtask
  task automatic t_skip_dec();
    run(OP_DEC_SKIP, 7'h10, DEST_REG, 8'h05, LIT_RESET);
    run(OP_INC, 7'h11, DEST_ACC, 8'h41, LIT_RESET);
    run(OP_DEC_SKIP, 7'h12, DEST_ACC, 8'h01, LIT_RESET);
    run(OP_INC, 7'h13, DEST_REG, 8'h20, LIT_RESET);
    $display("test skip dec done");
  endtask
  task automatic t_skip_inc();
    run(OP_INC_SKIP, 7'h20, DEST_ACC, 8'h10, LIT_RESET);
    run(OP_INC_SKIP, 7'h7F, DEST_REG, 8'hFF, LIT_RESET);
    run(OP_DEC, 7'h21, DEST_ACC, 8'h09, LIT_RESET);
    $display("test skip inc done");
  endtask
  task automatic t_jump();
    pc_high_latch = 8'hF7;
    run(OP_JUMP, 7'h00, DEST_ACC, 8'h00, 11'h7FF);
    run(OP_INC, 7'h30, DEST_ACC, 8'h33, LIT_RESET);
    pc_high_latch = 8'h08;
    run(OP_JUMP, 7'h00, DEST_ACC, 8'h00, 11'h000);
    run(OP_DEC, 7'h31, DEST_REG, 8'h44, LIT_RESET);
    $display("test jump done");
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    chk(16'(pc), 16'(PC_RESET));
    reset = 1'b0;
    @(negedge ref_clk);
    t_plain();
    t_skip_dec();
    t_skip_inc();
    t_jump();
    tally_and_finish();
  end
endmodule
`default_nettype wire
